// *** hdl/irb_pkg.sv ***
// Constants for the interrupt request and enable bank
package irb_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 12;
	localparam int          DATA_W     = 8;
	localparam logic [11:0] OFS_PEND0  = 12'hfc0;
	localparam logic [11:0] OFS_ENH0   = 12'hfc1;
	localparam logic [11:0] OFS_ENL0   = 12'hfc2;
	localparam logic [11:0] OFS_PEND1  = 12'hfc3;
	localparam logic [11:0] OFS_PEND2  = 12'hfc6;
	localparam logic [7:0]  RESET_VAL  = 8'h00;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int          BIT_TIMER1 = 6;
	localparam int          BIT_TIMER0 = 5;
	localparam int          BIT_CONV   = 0;
	localparam logic [7:0]  MASK_REG0  = 8'h61;
	localparam logic [7:0]  MASK_REG2  = 8'h0f;

	// ----------------------------------------------------------------
	// Flat source vector, bit 14 wins ties
	// ----------------------------------------------------------------
	localparam int          NUM_SRC    = 15;
	localparam int          SRC_W      = 4;
	localparam int          SRC_TIMER1 = 14;
	localparam int          SRC_TIMER0 = 13;
	localparam int          SRC_CONV   = 12;
	localparam int          SRC_PA_LO  = 4;
	localparam int          SRC_PA_HI  = 11;
	localparam int          SRC_PC_LO  = 0;
	localparam int          SRC_PC_HI  = 3;

	typedef enum logic [1:0] {
		IRB_LVL_OFF = 2'b00,
		IRB_LVL_1   = 2'b01,
		IRB_LVL_2   = 2'b10,
		IRB_LVL_3   = 2'b11
	} irb_lvl_e;

endpackage

// *** hdl/irb_arbiter.sv ***
// Priority picker over all enabled pending sources
`timescale 1ns/1ps

module irb_arbiter
(
	input  wire logic [14:0] pend,
	input  wire logic [14:0] prio_high,
	input  wire logic [14:0] prio_low,
	output logic             found,
	output logic [3:0]       win_src,
	output logic [1:0]       win_lvl
);

	logic [1:0] lvl;

	always_comb
	begin
		lvl     = irb_pkg::IRB_LVL_OFF;
		found   = 1'b0;
		win_src = 4'h0;
		win_lvl = irb_pkg::IRB_LVL_OFF;
		// Ascending scan with >= lets the higher index win a tie
		for (int i = 0; i < irb_pkg::NUM_SRC; i++)
		begin
			lvl = {prio_high[i], prio_low[i]};
			if (pend[i] && lvl != irb_pkg::IRB_LVL_OFF
				&& lvl >= win_lvl)
			begin
				found   = 1'b1;
				win_src = 4'(i);
				win_lvl = lvl;
			end
		end
	end

endmodule // irb_arbiter

// *** hdl/irb_bank.sv ***
// Interrupt request latching and priority-enable register bank
//
// Function
// - Watchdog and oscillator traps stay outside here
// - Source request sets its pending bit, sticky
// - Global enable on: forward winning request
// - Global enable off: no request, polling only
// - Enable pair gives off or level 1-3
// - Request reg 0: timer1 b6, timer0 b5, ADC b0
// - Request reg 1: port A pins; b6 shared comparator
// - Request reg 2: port C pins in bits 3:0
// - Enable regs 0 mirror request reg 0 layout
// - All request and enable bits reset zero
// - Ack or written zero clears pending bit
// - Written one raises the interrupt
// - Level 3 over 2 over 1, fixed order
`timescale 1ns/1ps

module irb_bank
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata_r,
	input  wire logic        timer1_req,
	input  wire logic        timer0_req,
	input  wire logic        converter_req,
	input  wire logic [7:0]  porta_req,
	input  wire logic        comparator_req,
	input  wire logic [3:0]  portc_req,
	input  wire logic [7:0]  porta_prio_high,
	input  wire logic [7:0]  porta_prio_low,
	input  wire logic [3:0]  portc_prio_high,
	input  wire logic [3:0]  portc_prio_low,
	input  wire logic        global_irq_enable,
	input  wire logic        irq_ack,
	input  wire logic [3:0]  irq_ack_src,
	output logic             irq_req_r,
	output logic [3:0]       irq_src_r,
	output logic [1:0]       irq_lvl_r
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [14:0] pend_r;
	logic [14:0] pend_nxt;
	logic [7:0]  enh0_r;
	logic [7:0]  enh0_nxt;
	logic [7:0]  enl0_r;
	logic [7:0]  enl0_nxt;
	logic [7:0]  rdata_nxt;
	logic        req_nxt;
	logic [3:0]  src_nxt;
	logic [1:0]  lvl_nxt;
	logic [14:0] hw_set;
	logic [14:0] ack_clr;
	logic [14:0] prio_high;
	logic [14:0] prio_low;
	logic [7:0]  view0;
	logic [7:0]  view2;
	logic        found;
	logic [3:0]  win_src;
	logic [1:0]  win_lvl;

	// Watchdog and oscillator traps have no bit in this bank

	// ----------------------------------------------------------------
	// Source pulses into the flat vector
	// ----------------------------------------------------------------
	always_comb
	begin
		hw_set = {timer1_req, timer0_req, converter_req,
			porta_req, portc_req};
		hw_set[irb_pkg::SRC_PA_LO + 6] = porta_req[6] | comparator_req;
	end

	always_comb
	begin
		ack_clr = 15'h0000;
		if (irq_ack)
			ack_clr = 15'h0001 << irq_ack_src;
	end

	// ----------------------------------------------------------------
	// Pending bits
	// ----------------------------------------------------------------
	always_comb
	begin
		pend_nxt = pend_r & ~ack_clr;
		if (reg_wr && hit(reg_addr, irb_pkg::OFS_PEND0))
		begin
			pend_nxt[irb_pkg::SRC_TIMER1] = reg_wdata[irb_pkg::BIT_TIMER1];
			pend_nxt[irb_pkg::SRC_TIMER0] = reg_wdata[irb_pkg::BIT_TIMER0];
			pend_nxt[irb_pkg::SRC_CONV]   = reg_wdata[irb_pkg::BIT_CONV];
		end
		if (reg_wr && hit(reg_addr, irb_pkg::OFS_PEND1))
			pend_nxt[irb_pkg::SRC_PA_HI:irb_pkg::SRC_PA_LO] = reg_wdata;
		if (reg_wr && hit(reg_addr, irb_pkg::OFS_PEND2))
			pend_nxt[irb_pkg::SRC_PC_HI:irb_pkg::SRC_PC_LO] =
				reg_wdata[3:0];
		// Set after every clear so no pulse is lost
		pend_nxt = pend_nxt | hw_set;
	end

	// ----------------------------------------------------------------
	// Enable registers for request reg 0
	// ----------------------------------------------------------------
	always_comb
	begin
		enh0_nxt = enh0_r;
		enl0_nxt = enl0_r;
		// Reserved bits are dropped, so they always read zero
		if (reg_wr && hit(reg_addr, irb_pkg::OFS_ENH0))
			enh0_nxt = reg_wdata & irb_pkg::MASK_REG0;
		if (reg_wr && hit(reg_addr, irb_pkg::OFS_ENL0))
			enl0_nxt = reg_wdata & irb_pkg::MASK_REG0;
	end

	// ----------------------------------------------------------------
	// Read views
	// ----------------------------------------------------------------
	always_comb
	begin
		view0 = irb_pkg::RESET_VAL;
		view0[irb_pkg::BIT_TIMER1] = pend_r[irb_pkg::SRC_TIMER1];
		view0[irb_pkg::BIT_TIMER0] = pend_r[irb_pkg::SRC_TIMER0];
		view0[irb_pkg::BIT_CONV]   = pend_r[irb_pkg::SRC_CONV];
		view2 = {4'h0, pend_r[irb_pkg::SRC_PC_HI:irb_pkg::SRC_PC_LO]};
	end

	always_comb
	begin
		rdata_nxt = reg_rdata_r;
		if (reg_rd)
		begin
			// Unmapped addresses answer zero
			rdata_nxt = irb_pkg::RESET_VAL;
			if (hit(reg_addr, irb_pkg::OFS_PEND0))
				rdata_nxt = view0;
			if (hit(reg_addr, irb_pkg::OFS_ENH0))
				rdata_nxt = enh0_r;
			if (hit(reg_addr, irb_pkg::OFS_ENL0))
				rdata_nxt = enl0_r;
			if (hit(reg_addr, irb_pkg::OFS_PEND1))
				rdata_nxt = pend_r[irb_pkg::SRC_PA_HI:irb_pkg::SRC_PA_LO];
			if (hit(reg_addr, irb_pkg::OFS_PEND2))
				rdata_nxt = view2;
		end
	end

	// ----------------------------------------------------------------
	// Arbitration and request to the core
	// ----------------------------------------------------------------
	always_comb
	begin
		prio_high = {enh0_r[irb_pkg::BIT_TIMER1], enh0_r[irb_pkg::BIT_TIMER0],
			enh0_r[irb_pkg::BIT_CONV], porta_prio_high, portc_prio_high};
		prio_low  = {enl0_r[irb_pkg::BIT_TIMER1], enl0_r[irb_pkg::BIT_TIMER0],
			enl0_r[irb_pkg::BIT_CONV], porta_prio_low, portc_prio_low};
	end

	irb_arbiter u_arb
	(
		.pend      (pend_r),
		.prio_high (prio_high),
		.prio_low  (prio_low),
		.found     (found),
		.win_src   (win_src),
		.win_lvl   (win_lvl)
	);

	always_comb
	begin
		// Drop the request in the ack cycle so it is not seen twice
		req_nxt = global_irq_enable && found && !irq_ack;
		src_nxt = irq_src_r;
		lvl_nxt = irq_lvl_r;
		if (found)
		begin
			src_nxt = win_src;
			lvl_nxt = win_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pend_r      <= 15'h0000;
			enh0_r      <= irb_pkg::RESET_VAL;
			enl0_r      <= irb_pkg::RESET_VAL;
			reg_rdata_r <= irb_pkg::RESET_VAL;
			irq_req_r   <= 1'b0;
			irq_src_r   <= 4'h0;
			irq_lvl_r   <= irb_pkg::IRB_LVL_OFF;
		end
		else
		begin
			pend_r      <= pend_nxt;
			enh0_r      <= enh0_nxt;
			enl0_r      <= enl0_nxt;
			reg_rdata_r <= rdata_nxt;
			irq_req_r   <= req_nxt;
			irq_src_r   <= src_nxt;
			irq_lvl_r   <= lvl_nxt;
		end
	end

endmodule // irb_bank

// *** sim/irb_bank_asserts.sv ***
// Port checks for the request bank
`timescale 1ns/1ps
module irb_bank_asserts
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [11:0] reg_addr,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_rdata_r,
	input wire logic [7:0]  porta_req,
	input wire logic [7:0]  porta_prio_high,
	input wire logic [7:0]  porta_prio_low,
	input wire logic        global_irq_enable,
	input wire logic        irq_ack,
	input wire logic        irq_req_r,
	input wire logic [3:0]  irq_src_r,
	input wire logic [1:0]  irq_lvl_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Pairs as the registered outputs saw them
	logic [7:0] ph_q, pl_q;
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			{ph_q, pl_q} <= 16'h0000;
		else
			{ph_q, pl_q} <= {porta_prio_high, porta_prio_low};
	chk_gie_off:
	assert property (!global_irq_enable |=> !irq_req_r) else $error("req");
	chk_ack_drop:
	assert property (irq_ack |=> !irq_req_r) else $error("ack");
	chk_lvl_match:
	assert property (irq_req_r && irq_src_r inside {[4'h4:4'hb]} |->
		irq_lvl_r == {ph_q[irq_src_r - 4'h4], pl_q[irq_src_r - 4'h4]})
		else $error("level");
	chk_src_range:
	assert property (irq_req_r |-> irq_src_r <= 4'he && irq_lvl_r != 2'b00)
		else $error("src");
	chk_reset_zero:
	assert property ($rose(nrst) |-> reg_rdata_r == 8'h00 && !irq_req_r)
		else $error("reset");
	chk_rsvd_bank0:
	assert property (reg_rd && reg_addr inside {12'hfc0, 12'hfc1, 12'hfc2}
		|=> (reg_rdata_r & 8'h9e) == 8'h00) else $error("rsvd0");
	chk_rsvd_bank2:
	assert property (reg_rd && reg_addr == 12'hfc6
		|=> reg_rdata_r[7:4] == 4'h0) else $error("rsvd2");
	chk_pin7_forward:
	assert property (porta_req[7] ##1 (global_irq_enable && !irq_ack
		&& !reg_wr && porta_prio_high[7] && porta_prio_low[7])
		|=> irq_req_r && irq_lvl_r == 2'b11) else $error("fwd");
	cover property (irq_ack);
	cover property (irq_req_r && irq_lvl_r == 2'b01);
	cover property (reg_rd && reg_addr == 12'hfc4);
endmodule // irb_bank_asserts

// *** sim/irb_core_model.sv ***
// Core stand-in acknowledging vectored requests
`timescale 1ns/1ps
module irb_core_model
(
	input  wire logic       clk,
	input  wire logic       en,
	input  wire logic [1:0] slow,
	input  wire logic       irq_req_r,
	input  wire logic [3:0] irq_src_r,
	output logic            irq_ack,
	output logic [3:0]      irq_ack_src
);
	// Acks only a live request; source shows garbage when idle
	initial
	begin
		irq_ack = 1'b0;
		irq_ack_src = 4'h0;
		forever
		begin
			@(posedge clk);
			#1;
			if (en && irq_req_r === 1'b1)
			begin
				repeat (slow) @(posedge clk);
				#1;
				if (irq_req_r === 1'b1)
				begin
					irq_ack = 1'b1;
					irq_ack_src = irq_src_r;
					@(posedge clk);
					#1;
					irq_ack = 1'b0;
					irq_ack_src = ~irq_ack_src;
				end
			end
		end
	end
endmodule // irb_core_model

// *** sim/tb_irb_bank.sv ***
// Self-checking bench for the request bank
`timescale 1ns/1ps
module tb_irb_bank;
	logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        gie = 1'b0, en = 1'b0, cmpr = 1'b0;
	logic        irq_ack, irq_req_r;
	logic [1:0]  slow = 2'b00, irq_lvl_r, lvl_s;
	logic [3:0]  irq_ack_src, irq_src_r, pc_h = 4'h0, pc_l = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata_r, pa_h = 8'h00, pa_l = 8'h00;
	logic [11:0] reg_addr = 12'h000;
	logic [14:0] pulse = 15'h0000;
	logic [7:0]  exp_q [$];
	int          err_count = 0, checks = 0, i, d;
	logic [11:0] ad [5] = '{12'hfc0, 12'hfc1, 12'hfc2, 12'hfc3, 12'hfc6};
	logic [7:0]  mk [5] = '{8'h61, 8'h61, 8'h61, 8'hff, 8'h0f};
	logic [7:0]  ord [14] = '{8'hcd, 8'hcb, 8'h8e, 8'h8c, 8'h4a, 8'h49,
		8'h48, 8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41};
	always #10 clk = ~clk;
	irb_bank irb_bank_i (.clk, .nrst, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata_r, .timer1_req(pulse[14]),
		.timer0_req(pulse[13]), .converter_req(pulse[12]),
		.porta_req(pulse[11:4]), .comparator_req(cmpr),
		.portc_req(pulse[3:0]), .porta_prio_high(pa_h),
		.porta_prio_low(pa_l), .portc_prio_high(pc_h),
		.portc_prio_low(pc_l), .global_irq_enable(gie), .irq_ack,
		.irq_ack_src, .irq_req_r, .irq_src_r, .irq_lvl_r);
	irb_core_model irb_core_model_i (.clk, .en, .slow, .irq_req_r,
		.irq_src_r, .irq_ack, .irq_ack_src);
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] v);
		exp_q.push_back(v);
		reg_addr = a;
		reg_rd = 1'b1;
		tick();
		reg_rd = 1'b0;
		tick();
	endtask
	task automatic fire(input logic [14:0] p, input logic c);
		pulse = p;
		cmpr = c;
		tick();
		pulse = 15'h0000;
		cmpr = 1'b0;
	endtask
	task automatic cmp(input logic [7:0] v);
		logic [7:0] e;
		e = exp_q.size() ? exp_q.pop_front() : 8'hxx;
		checks++;
		if (v !== e)
		begin
			err_count++;
			$display("FAIL t=%0t got %h exp %h", $time, v, e);
		end
	endtask
	task automatic print_verdict(input bit hung);
		if (hung)
			err_count++;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic done(input string s);
		for (d = 0; d < 400 && exp_q.size() != 0; d++)
			tick();
		if (exp_q.size() != 0)
			print_verdict(1'b1);
		$display("test %s done", s);
	endtask
	// Level as it stood before the ack edge relaunches it
	always @(negedge clk)
		lvl_s <= irq_lvl_r;
	always @(posedge clk)
	begin
		if (irq_ack === 1'b1)
			cmp({lvl_s, 2'b00, irq_ack_src});
		if (reg_rd === 1'b1)
		begin
			#1;
			cmp(reg_rdata_r);
		end
	end
	initial
	begin
		void'($urandom(37));
		tick(2);
		nrst = 1'b1;
		foreach (ad[i]) rd(ad[i], 8'h00);
		rd(12'hfc4, 8'h00);
		done("reset");
		for (i = 0; i < 5; i++)
		begin
			d = $urandom;
			wr(ad[i], d[7:0] & mk[i]);
			rd(ad[i], d[7:0] & mk[i]);
			wr(ad[i], 8'h00);
		end
		done("registers");
		d = $urandom;
		fire({3'b111, d[7:0] & 8'hbf, 4'hf}, 1'b1);
		rd(12'hfc0, 8'h61);
		rd(12'hfc3, d[7:0] | 8'h40);
		// Pin pulse races a clearing write
		reg_addr = 12'hfc6;
		reg_wdata = 8'h00;
		reg_wr = 1'b1;
		pulse = 15'h0002;
		tick();
		reg_wr = 1'b0;
		pulse = 15'h0000;
		rd(12'hfc6, 8'h02);
		wr(12'hfc0, 8'h20);
		rd(12'hfc0, 8'h20);
		foreach (ad[i]) wr(ad[i], 8'h00);
		done("latching");
		wr(12'hfc1, 8'h61);
		wr(12'hfc2, 8'h20);
		{pa_h, pa_l, pc_l} = {8'h80, 8'hff, 4'he};
		slow = 2'($urandom);
		gie = 1'b1;
		en = 1'b1;
		foreach (ord[i]) exp_q.push_back(ord[i]);
		fire(15'h7fff, 1'b0);
		done("arbitration");
		rd(12'hfc6, 8'h01);
		exp_q.push_back(8'hcd);
		wr(12'hfc0, 8'h20);
		done("software set");
		gie = 1'b0;
		fire(15'h4000, 1'b0);
		tick(4);
		exp_q.push_back(8'h00);
		cmp({7'h00, irq_req_r});
		rd(12'hfc0, 8'h40);
		done("polled");
		nrst = 1'b0;
		tick(2);
		nrst = 1'b1;
		rd(12'hfc0, 8'h00);
		rd(12'hfc1, 8'h00);
		done("mid reset");
		print_verdict(1'b0);
	end
endmodule // tb_irb_bank
bind irb_bank irb_bank_asserts irb_bank_asserts_i (.clk, .nrst,
	.reg_addr, .reg_rd, .reg_wr, .reg_rdata_r, .porta_req,
	.porta_prio_high, .porta_prio_low, .global_irq_enable, .irq_ack,
	.irq_req_r, .irq_src_r, .irq_lvl_r);
